/* File: src/serial_sar_adc_readout.sv */
// Function
// - Select, shift clock, serial data out pins
// - Falling select starts conversion and transfer
// - Sample during first two shift-clock periods
// - Second fall enables output, drives null bit
// - Twelve bits follow, MSB first, decided live
// - Output changes on shift-clock falling edges
// - After LSB, repeat result LSB first
// - After repeated MSB, float and ignore clocks
// - New conversion needs select high then low
// - Result is 12-bit signed two's complement
// - One step is two reference over 4096
// - Full scale 800h/7FFh, zero 000h, FFFh
// - Shifted bits belong to current conversion
// - Raising select ends conversion at once
// - Analog power down on completion, full power down on select high
`timescale 1ns/1ps

module serial_sar_adc_readout
  import adc_readout_pkg::*;
#(
  parameter int WIDTH = `ADC_RESULT_W,
  parameter int SYNC_STAGES = `ADC_SYNC_STAGES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial pins
  input wire logic cs_n,
  input wire logic serial_shift_clock,
  output logic dout,
  output logic dout_oe,
  // Analog front end
  input wire logic cmp_above,
  output logic sample_en,
  output logic [WIDTH-1:0] dac_code,
  output logic analog_pd,
  output logic digital_pd,
  // Parallel result
  output logic [WIDTH-1:0] result,
  output logic result_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic cs_n_s;
  logic sclk_s;
  logic cmp_s;

  bit_sync #(.STAGES(SYNC_STAGES)) u_sync_cs (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(cs_n),
    .sync_out(cs_n_s)
  );

  bit_sync #(.STAGES(SYNC_STAGES)) u_sync_sclk (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(serial_shift_clock),
    .sync_out(sclk_s)
  );

  bit_sync #(.STAGES(SYNC_STAGES)) u_sync_cmp (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(cmp_above),
    .sync_out(cmp_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Successive approximation register

  sar_if #(.WIDTH(WIDTH)) sif ();

  sar_core #(.WIDTH(WIDTH)) u_sar (
    .ref_clk(ref_clk),
    .rst(rst),
    .sif(sif.core)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bit sequencer

  readout_s s_q;
  readout_s s_d;
  logic sclk_fall;
  logic sar_start;
  logic sar_step;
  logic bit_val;
  fall_cnt_t falls_inc;
  fall_cnt_t rep_idx;

  always_comb begin
    s_d = s_q;
    sar_start = 1'b0;
    sar_step = 1'b0;
    bit_val = 1'b0;
    rep_idx = '0;
    s_d.sclk_prev = sclk_s;
    s_d.cs_prev = cs_n_s;
    sclk_fall = s_q.sclk_prev & ~sclk_s;
    falls_inc = s_q.falls + `ADC_FALLS_RST + 5'h01;
    if (cs_n_s) begin
      // Select high: float, idle, full power down
      s_d.st = SEQ_IDLE;
      s_d.falls = `ADC_FALLS_RST;
      s_d.dout = 1'b0;
      s_d.dout_oe = 1'b0;
      s_d.sample_en = 1'b0;
      s_d.analog_pd = 1'b1;
      s_d.digital_pd = 1'b1;
    end else begin
      case (s_q.st)
        SEQ_IDLE: begin
          // Only a fresh high-to-low select starts a cycle
          if (s_q.cs_prev) begin
            s_d.st = SEQ_SAMPLE;
            s_d.falls = `ADC_FALLS_RST;
            s_d.sample_en = 1'b1;
            s_d.analog_pd = 1'b0;
            s_d.digital_pd = 1'b0;
            s_d.result_valid = 1'b0;
            sar_start = 1'b1;
          end
        end
        SEQ_SAMPLE: begin
          if (sclk_fall) begin
            s_d.falls = falls_inc;
            if (falls_inc == `ADC_NULL_FALL) begin
              s_d.st = SEQ_NULL;
              s_d.sample_en = 1'b0;
              s_d.dout_oe = 1'b1;
              s_d.dout = 1'b0;
            end
          end
        end
        SEQ_NULL, SEQ_CONVERT: begin
          if (sclk_fall) begin
            s_d.falls = falls_inc;
            sar_step = 1'b1;
            // Sign bit is the inverted offset-binary MSB
            bit_val = (s_q.st == SEQ_NULL) ? ~cmp_s : cmp_s;
            s_d.dout = bit_val;
            s_d.result = {s_q.result[WIDTH-2:0], bit_val};
            s_d.st = SEQ_CONVERT;
            if (falls_inc == `ADC_LAST_BIT_FALL) begin
              s_d.st = SEQ_REPEAT;
              s_d.result_valid = 1'b1;
              s_d.analog_pd = 1'b1;
            end
          end
        end
        SEQ_REPEAT: begin
          if (sclk_fall) begin
            s_d.falls = falls_inc;
            rep_idx = falls_inc - `ADC_LAST_BIT_FALL;
            if (falls_inc == `ADC_FLOAT_FALL) begin
              s_d.st = SEQ_DONE;
              s_d.dout = 1'b0;
              s_d.dout_oe = 1'b0;
            end else begin
              s_d.dout = s_q.result[rep_idx[3:0]];
            end
          end
        end
        SEQ_DONE: begin
          // Further clocks ignored until select rises
          s_d.st = SEQ_DONE;
        end
        default: begin
          s_d.st = SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q.st <= SEQ_IDLE;
      s_q.falls <= `ADC_FALLS_RST;
      s_q.sclk_prev <= 1'b0;
      // Synchroniser resets low, so a high here would fake a select fall
      s_q.cs_prev <= 1'b0;
      s_q.dout <= 1'b0;
      s_q.dout_oe <= 1'b0;
      s_q.sample_en <= 1'b0;
      s_q.analog_pd <= 1'b1;
      s_q.digital_pd <= 1'b1;
      s_q.result <= `ADC_RESULT_RST;
      s_q.result_valid <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.start = sar_start;
  assign sif.step = sar_step;
  assign sif.cmp = cmp_s;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dout = s_q.dout;
  assign dout_oe = s_q.dout_oe;
  assign sample_en = s_q.sample_en;
  assign dac_code = sif.code;
  assign analog_pd = s_q.analog_pd;
  assign digital_pd = s_q.digital_pd;
  assign result = s_q.result;
  assign result_valid = s_q.result_valid;

endmodule : serial_sar_adc_readout

/* File: src/adc_readout_defs.svh */
`ifndef ADC_READOUT_DEFS_SVH
`define ADC_READOUT_DEFS_SVH

// Result width and sequencer fall counts
`define ADC_RESULT_W 12
`define ADC_FALL_CNT_W 5
`define ADC_NULL_FALL 5'h02
`define ADC_LAST_BIT_FALL 5'h0E
`define ADC_FLOAT_FALL 5'h1A

// Synchroniser depth
`define ADC_SYNC_STAGES 2

// Reset values
`define ADC_FALLS_RST 5'h00
`define ADC_RESULT_RST 12'h000

`endif

/* File: src/adc_readout_pkg.sv */
`include "adc_readout_defs.svh"

package adc_readout_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_SAMPLE = 3'b001,
    SEQ_NULL = 3'b011,
    SEQ_CONVERT = 3'b010,
    SEQ_REPEAT = 3'b110,
    SEQ_DONE = 3'b111
  } seq_state_e;

  typedef logic [`ADC_RESULT_W-1:0] code_t;
  typedef logic [`ADC_FALL_CNT_W-1:0] fall_cnt_t;

  typedef struct packed {
    seq_state_e st;
    fall_cnt_t falls;
    logic sclk_prev;
    logic cs_prev;
    logic dout;
    logic dout_oe;
    logic sample_en;
    logic analog_pd;
    logic digital_pd;
    code_t result;
    logic result_valid;
  } readout_s;

  typedef struct packed {
    code_t code;
    code_t mask;
  } sar_s;

endpackage : adc_readout_pkg

/* File: src/sar_if.sv */
`timescale 1ns/1ps

interface sar_if #(
  parameter int WIDTH = 12
);
  logic start;
  logic step;
  logic cmp;
  logic [WIDTH-1:0] code;

  modport ctrl (output start, output step, output cmp, input code);
  modport core (input start, input step, input cmp, output code);
endinterface : sar_if

/* File: src/bit_sync.sv */
`timescale 1ns/1ps

module bit_sync #(
  parameter int STAGES = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Level in and out
  input wire logic async_in,
  output logic sync_out
);

  typedef struct packed {
    logic [STAGES-1:0] stage;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // Stage 0 feeds only stage 1
  always_comb begin
    s_d = s_q;
    s_d.stage = {s_q.stage[STAGES-2:0], async_in};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stage[STAGES-1];

endmodule : bit_sync

/* File: src/sar_core.sv */
`timescale 1ns/1ps

module sar_core
  import adc_readout_pkg::*;
#(
  parameter int WIDTH = `ADC_RESULT_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Sequencer side
  sar_if.core sif
);

  sar_s s_q;
  sar_s s_d;
  code_t kept;

  // Offset-binary trial register, one decision per step
  always_comb begin
    s_d = s_q;
    kept = '0;
    if (sif.start) begin
      s_d.code = {1'b1, {(WIDTH-1){1'b0}}};
      s_d.mask = {1'b1, {(WIDTH-1){1'b0}}};
    end else if (sif.step) begin
      kept = sif.cmp ? s_q.code : (s_q.code & ~s_q.mask);
      s_d.mask = s_q.mask >> 1;
      s_d.code = kept | (s_q.mask >> 1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.code = s_q.code;

endmodule : sar_core

/* File: sim/adc_readout_monitor.sv */
`timescale 1ns/1ps

module adc_readout_monitor #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial pins
  input wire logic cs_n,
  input wire logic serial_shift_clock,
  input wire logic dout,
  input wire logic dout_oe,
  // Analog front end
  input wire logic cmp_above,
  input wire logic sample_en,
  input wire logic [WIDTH-1:0] dac_code,
  input wire logic analog_pd,
  input wire logic digital_pd,
  // Parallel result
  input wire logic [WIDTH-1:0] result,
  input wire logic result_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_cs_idle;
    cs_n [*5];
  endsequence
  sequence s_start;
    $rose(sample_en);
  endsequence
  sequence s_floated_low_cs;
    $fell(dout_oe) && !cs_n;
  endsequence

  a_idle_float: assert property (s_cs_idle |-> !dout_oe && !sample_en && analog_pd && digital_pd)
    else $error("not idle while deselected");
  a_null_low: assert property ($rose(dout_oe) |-> !dout && !sample_en)
    else $error("null bit wrong");
  a_start_fall: assert property (s_start |-> $past(cs_n, 4) && !cs_n && dac_code == 12'h800)
    else $error("bad conversion start");
  a_bit_on_fall: assert property ($changed(dout) |-> $past(!serial_shift_clock, 2))
    else $error("output moved without a fall");
  a_valid_pd: assert property ($rose(result_valid) |-> analog_pd && !digital_pd && dout_oe)
    else $error("power state wrong at end");
  a_lsb_last: assert property ($rose(result_valid) |-> dout == result[0])
    else $error("last bit not lsb");
  a_result_hold: assert property (result_valid && $past(result_valid) |-> $stable(result))
    else $error("result moved while valid");
  a_float_after_msb: assert property (s_floated_low_cs |-> result_valid && $past(dout) == result[WIDTH-1])
    else $error("float not after repeated msb");
endmodule : adc_readout_monitor

bind serial_sar_adc_readout adc_readout_monitor #(.WIDTH(WIDTH)) u_mon (.*);

/* File: sim/adc_host_model.sv */
`timescale 1ns/1ps

module adc_host_model (
  // Clock and pins
  input wire logic ref_clk,
  input wire logic cs_n,
  input wire logic serial_shift_clock,
  input wire logic dout,
  input wire logic dout_oe,
  // Captured words
  output logic [11:0] msb_word,
  output logic [10:0] rep_word
);
  logic last_q = 1'h0;
  logic line;
  int rises = 0;

  // Released line shows the inverse of its last value
  assign line = dout_oe ? dout : ~last_q;
  always @(posedge ref_clk) if (dout_oe) last_q <= dout;

  // Capture on rising edges, skipping sampling and null
  always @(posedge serial_shift_clock or posedge cs_n) begin
    if (cs_n) begin
      rises <= 0;
    end else begin
      rises <= rises + 1;
      if (rises >= 3 && rises <= 14) msb_word <= {msb_word[10:0], line};
      if (rises >= 15 && rises <= 25) rep_word <= {line, rep_word[10:1]};
    end
  end
endmodule : adc_host_model

/* File: sim/tb_serial_sar_adc_readout.sv */
`timescale 1ns/1ps

module tb_serial_sar_adc_readout;
  import adc_readout_pkg::*;
  typedef struct packed {code_t vin; code_t exp;} row_s;
  logic ref_clk = 1'h0, rst = 1'h1, cs_n = 1'h1, sclk = 1'h0, cmp_above = 1'h0;
  logic dout, dout_oe, sample_en, analog_pd, digital_pd, result_valid;
  code_t dac_code, result;
  code_t tgt = 12'h000;
  logic [11:0] msb_word;
  logic [10:0] rep_word;
  int miscompares = 0, n_tests = 0, cyc = 0;
  row_s rows [5] = '{'{12'h800, 12'h800}, '{12'h7FF, 12'h7FF}, '{12'h000, 12'h000},
    '{12'hFFF, 12'hFFF}, '{12'h5A3, 12'h5A3}};

  serial_sar_adc_readout uut (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .serial_shift_clock(sclk),
    .dout(dout), .dout_oe(dout_oe), .cmp_above(cmp_above), .sample_en(sample_en), .dac_code(dac_code),
    .analog_pd(analog_pd), .digital_pd(digital_pd), .result(result), .result_valid(result_valid));
  adc_host_model u_host (.ref_clk(ref_clk), .cs_n(cs_n), .serial_shift_clock(sclk), .dout(dout),
    .dout_oe(dout_oe), .msb_word(msb_word), .rep_word(rep_word));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // Ideal comparator for an input whose code is tgt
  always @(negedge ref_clk) cmp_above <= (tgt ^ 12'h800) >= dac_code;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input code_t got, input code_t exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({11'h000, got}, {11'h000, exp});
  endtask : chk1
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (8) @(negedge ref_clk);
      sclk = 1'h1;
      repeat (8) @(negedge ref_clk);
      sclk = 1'h0;
    end
  endtask : pulses
  task automatic tally_and_finish;
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (12) @(negedge ref_clk);
    rst = 1'h0;
    repeat (6) @(negedge ref_clk);
    chk1(dout_oe, 1'h0);
    chk1(analog_pd & digital_pd, 1'h1);
    chk(result, 12'h000);
    $display("reset test done");
    foreach (rows[i]) begin
      tgt = rows[i].vin;
      cs_n = 1'h0;
      pulses(15);
      chk(msb_word, rows[i].exp);
      chk(result, rows[i].exp);
      chk1(result_valid, 1'h1);
      pulses(12);
      chk({1'h0, rep_word}, {1'h0, rows[i].exp[11:1]});
      chk1(dout_oe, 1'h0);
      pulses(3);
      chk1(sample_en | dout_oe, 1'h0);
      chk1(digital_pd, 1'h0);
      cs_n = 1'h1;
      repeat (8) @(negedge ref_clk);
      chk1(digital_pd, 1'h1);
      $display("row %0d done", i);
    end
    tgt = 12'h7FF;
    cs_n = 1'h0;
    pulses(6);
    chk({9'h000, msb_word[2:0]}, 12'h003);
    cs_n = 1'h1;
    repeat (6) @(negedge ref_clk);
    chk1(dout_oe, 1'h0);
    chk1(analog_pd, 1'h1);
    $display("abort test done");
    tally_and_finish();
  end
endmodule : tb_serial_sar_adc_readout
